// file: logic/dcc_comparator_ctrl.sv
// digital control, filtering, sync and edge flags for two analog comparators
//
// Functional notes
// - result high when positive input exceeds negative
// - enable bit runs comparator, clear powers down
// - result readable in control and mirror
// - internal result registered every cycle
// - invert bit flips the reported result
// - speed select resets to one, writable
// - hysteresis bit adds input separation voltage
// - result offered as timer gate source
// - sync captures on timer clock falling edge
// - enabled rising/falling edges set irq flag
// - flag sticky, set wins over clear
// - disabled comparator still edges via invert/enable
// - positive select routes pin, dac, reference, ground
// - disabled comparator disconnects all inputs
// - negative select routes pins, reference, ground
// - enabled amplifier drives shared negative input
// - filter holds transition against reversal 20ns
// - analog pins read zero in port data
// - positive codes 000,101,110,111; others float
// - negative codes 000-011,110,111; 100,101 float
// - filter active only while its bit set
`default_nettype none
module dcc_comparator_ctrl #(
   parameter int FILT_CYC = dcc_pkg::FILT_HOLD_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dcc_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog front end
   input wire logic [dcc_pkg::NUM_CMP-1:0] cmpRaw,
   input wire logic [dcc_pkg::NUM_CMP-1:0] ampEnable,
   output dcc_pkg::dcc_ana_t [dcc_pkg::NUM_CMP-1:0] anaCtl,
   // gated timer
   input wire logic timerClk,
   output logic [dcc_pkg::NUM_CMP-1:0] timerGate,
   // pin mapping
   output logic [dcc_pkg::NUM_CMP-1:0] pinOut,
   output logic [dcc_pkg::NUM_CMP-1:0] pinOutAllowed,
   input wire logic [dcc_pkg::PORT_W-1:0] portPins,
   // results and flags
   output logic [dcc_pkg::NUM_CMP-1:0] cmpResult,
   output logic [dcc_pkg::NUM_CMP-1:0] cmpIrqFlag
);
   import dcc_pkg::*;

   localparam int SW = PORT_W + 1 + NUM_CMP;

   // positive channel decode; unlisted codes leave every switch open
   function automatic dcc_pos_t decodePos(input logic en, input logic [CH_W-1:0] code);
      dcc_pos_t p;
      p = '0;
      if (en) begin
         p.pin = (code == PCH_PIN);
         p.dac = (code == PCH_DAC);
         p.fixed_reference_buffer = (code == PCH_FVR);
         p.gnd = (code == PCH_GND);
      end
      return p;
   endfunction

   // negative channel decode; codes 100 and 101 float
   function automatic dcc_neg_t decodeNeg(input logic en, input logic [CH_W-1:0] code);
      dcc_neg_t n;
      n = '0;
      if (en) begin
         if (code <= NCH_PIN_LAST) begin
            n.pin[code[1:0]] = 1'b1;
         end
         n.fixed_reference_buffer = (code == NCH_FVR);
         n.gnd = (code == NCH_GND);
      end
      return n;
   endfunction

   // control byte A as software reads it
   function automatic logic [BYTE_W-1:0] packA(input dcc_cfg_t c, input logic res);
      logic [BYTE_W-1:0] b;
      b = '0;
      b[CA_EN] = c.en;
      b[CA_OUT] = res;
      b[CA_POL] = c.pol;
      b[CA_ZLF] = c.zlf;
      b[CA_SP] = c.sp;
      b[CA_HYS] = c.hys;
      b[CA_SYNC] = c.sync;
      return b;
   endfunction

   function automatic logic [BYTE_W-1:0] packB(input dcc_cfg_t c);
      logic [BYTE_W-1:0] b;
      b = '0;
      b[CB_RISE] = c.rise;
      b[CB_FALL] = c.fall;
      b[CB_PCH_LSB +: CH_W] = c.pch;
      b[CB_NCH_LSB +: CH_W] = c.nch;
      return b;
   endfunction

   function automatic dcc_cfg_t writeA(input dcc_cfg_t c, input logic [BYTE_W-1:0] b);
      dcc_cfg_t r;
      r = c;
      r.en = b[CA_EN];
      r.pol = b[CA_POL];
      r.zlf = b[CA_ZLF];
      r.sp = b[CA_SP];
      r.hys = b[CA_HYS];
      r.sync = b[CA_SYNC];
      return r;
   endfunction

   function automatic dcc_cfg_t writeB(input dcc_cfg_t c, input logic [BYTE_W-1:0] b);
      dcc_cfg_t r;
      r = c;
      r.rise = b[CB_RISE];
      r.fall = b[CB_FALL];
      r.pch = b[CB_PCH_LSB +: CH_W];
      r.nch = b[CB_NCH_LSB +: CH_W];
      return r;
   endfunction

   function automatic dcc_cfg_t resetCfg();
      dcc_cfg_t r;
      r = '0;
      r = writeA(r, CTRLA_RST);
      r = writeB(r, CTRLB_RST);
      return r;
   endfunction

   // reset image of one comparator's configuration, speed select high
   localparam dcc_cfg_t CFG_RST = resetCfg();

   // apb decode
   wire logic setup = psel && !penable;
   wire logic access = psel && penable;
   wire logic hitCa0 = (paddr == OFF_CTRLA0);
   wire logic hitCb0 = (paddr == OFF_CTRLB0);
   wire logic hitCa1 = (paddr == OFF_CTRLA1);
   wire logic hitCb1 = (paddr == OFF_CTRLB1);
   wire logic hitMir = (paddr == OFF_MIRROR);
   wire logic hitFlg = (paddr == OFF_FLAGS);
   wire logic hitAns = (paddr == OFF_ANALOG_PIN_SELECT);
   wire logic hitPrt = (paddr == OFF_PORT);
   wire logic hitAny = hitCa0 || hitCb0 || hitCa1 || hitCb1 ||
                       hitMir || hitFlg || hitAns || hitPrt;
   wire logic wrEn = access && pwrite && hitAny;
   wire logic [BYTE_W-1:0] wrByte = pwdata[BYTE_W-1:0];
   // per-word write strobes; mirror and port words take no write and give no error
   wire logic wrCa0 = wrEn && hitCa0;
   wire logic wrCb0 = wrEn && hitCb0;
   wire logic wrCa1 = wrEn && hitCa1;
   wire logic wrCb1 = wrEn && hitCb1;
   wire logic wrFlg = wrEn && hitFlg;
   wire logic wrAns = wrEn && hitAns;

   // registers
   dcc_cfg_t cfg_q [NUM_CMP];
   dcc_cfg_t cfg_d [NUM_CMP];
   logic [PORT_W-1:0] analog_pin_select_q;
   logic [31:0] prdata_q;
   logic [NUM_CMP-1:0] result_q;
   logic [NUM_CMP-1:0] prev_q;
   logic [NUM_CMP-1:0] flag_q;
   logic [NUM_CMP-1:0] flag_d;
   logic [NUM_CMP-1:0] tsync_q;
   logic [NUM_CMP-1:0] polar;

   // three-stage synchroniser for comparators, timer clock and port pins
   // a one-cycle blip never reaches stable_q, as stages two and three must agree
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   logic [SW-1:0] s3_q;
   logic [SW-1:0] stable_q;
   wire logic [SW-1:0] syncIn = {portPins, timerClk, cmpRaw};
   wire logic [SW-1:0] agree = ~(s2_q ^ s3_q);
   wire logic [SW-1:0] stable_d = (agree & s2_q) | (~agree & stable_q);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         stable_q <= '0;
      end else begin
         s1_q <= syncIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         stable_q <= stable_d;
      end
   end

   wire logic [NUM_CMP-1:0] rawSync = stable_q[NUM_CMP-1:0];
   wire logic tclkSync = stable_q[NUM_CMP];
   wire logic tclkNext = stable_d[NUM_CMP];
   wire logic [PORT_W-1:0] portSync = stable_q[SW-1 -: PORT_W];
   // falling edge of the prescaled timer clock, counted once stages agree
   // the timer counts on the rise, so latching on the fall keeps the two apart
   wire logic tclkFall = tclkSync && !tclkNext;

   // per-comparator datapath
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
         wire logic gatedRaw = cfg_q[gi].en && rawSync[gi];
         wire logic filtered;
         wire logic rise = result_q[gi] && !prev_q[gi];
         wire logic fall = !result_q[gi] && prev_q[gi];
         wire logic setEv = (rise && cfg_q[gi].rise) || (fall && cfg_q[gi].fall);
         wire logic clrReq = wrFlg && wrByte[gi];

         dcc_glitch_filter #(
            .HOLD(FILT_CYC)
         ) u_filt (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .enable(cfg_q[gi].zlf),
            .din(gatedRaw),
            .dout(filtered)
         );

         // a disabled comparator reads low before the invert, so toggling
         // invert or enable can still produce an edge
         assign polar[gi] = filtered ^ cfg_q[gi].pol;
         // the set term wins so an edge during a clear is never lost
         assign flag_d[gi] = setEv || (flag_q[gi] && !clrReq);

         // sync mode feeds the timer gate and pin from the falling-edge latch
         assign timerGate[gi] = cfg_q[gi].sync ? tsync_q[gi] : result_q[gi];
         // the pin path stays unlatched unless sync is selected
         assign pinOut[gi] = cfg_q[gi].sync ? tsync_q[gi] : polar[gi];
         assign pinOutAllowed[gi] = cfg_q[gi].en;

         assign anaCtl[gi].en = cfg_q[gi].en;
         assign anaCtl[gi].speed = cfg_q[gi].sp;
         assign anaCtl[gi].hyst = cfg_q[gi].hys;
         assign anaCtl[gi].pos = decodePos(cfg_q[gi].en, cfg_q[gi].pch);
         assign anaCtl[gi].neg = decodeNeg(cfg_q[gi].en, cfg_q[gi].nch);
         assign anaCtl[gi].ampRoute = cfg_q[gi].en && ampEnable[gi] &&
                                      (cfg_q[gi].nch == NCH_AMP_SHARED);

         // each comparator owns its own pair of control words
         assign cfg_d[gi] = ((gi == 0) ? wrCa0 : wrCa1) ?
                               writeA(cfg_q[gi], wrByte) :
                            ((gi == 0) ? wrCb0 : wrCb1) ?
                               writeB(cfg_q[gi], wrByte) : cfg_q[gi];

         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               cfg_q[gi] <= CFG_RST;
            end else begin
               cfg_q[gi] <= cfg_d[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_q <= '0;
         prev_q <= '0;
         flag_q <= '0;
         tsync_q <= '0;
      end else begin
         result_q <= polar;
         prev_q <= result_q;
         flag_q <= flag_d;
         if (tclkFall) begin
            tsync_q <= polar;
         end
      end
   end

   // analog select and port readback
   wire logic [PORT_W-1:0] analog_pin_select_d = wrAns ? wrByte[PORT_W-1:0] : analog_pin_select_q;
   wire logic [PORT_W-1:0] portRead = portSync & ~analog_pin_select_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         analog_pin_select_q <= ANALOG_PIN_SELECT_RST;
      end else begin
         analog_pin_select_q <= analog_pin_select_d;
      end
   end

   // read decode, sampled in the setup cycle so data comes from a flop
   wire logic [BYTE_W-1:0] mirByte = {{(BYTE_W - NUM_CMP){1'b0}}, result_q};
   wire logic [BYTE_W-1:0] flgByte = {{(BYTE_W - NUM_CMP){1'b0}}, flag_q};
   logic [BYTE_W-1:0] rdByte;
   always_comb begin
      if (hitCa0) begin
         rdByte = packA(cfg_q[0], result_q[0]);
      end else if (hitCb0) begin
         rdByte = packB(cfg_q[0]);
      end else if (hitCa1) begin
         rdByte = packA(cfg_q[1], result_q[1]);
      end else if (hitCb1) begin
         rdByte = packB(cfg_q[1]);
      end else if (hitMir) begin
         rdByte = mirByte;
      end else if (hitFlg) begin
         rdByte = flgByte;
      end else if (hitAns) begin
         rdByte = analog_pin_select_q;
      end else if (hitPrt) begin
         rdByte = portRead;
      end else begin
         rdByte = '0;
      end
   end
   wire logic [31:0] prdata_d = (setup && !pwrite) ? {24'h00_0000, rdByte} : prdata_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_q <= RDATA_RST;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // zero wait states; unmapped addresses answer with an error
   wire logic unmapped = !hitAny;
   assign pready = access;
   assign pslverr = access && unmapped;
   assign prdata = prdata_q;
   assign cmpResult = result_q;
   assign cmpIrqFlag = flag_q;
endmodule
`default_nettype wire

// file: logic/dcc_pkg.sv
// constants, register map and carrier types for the dual comparator control block
`default_nettype none
package dcc_pkg;
   localparam int NUM_CMP = 2;
   localparam int APB_AW = 8;
   localparam int PORT_W = 8;
   localparam int BYTE_W = 8;
   localparam int SYNC_STAGES = 3;

   // register byte addresses
   localparam logic [APB_AW-1:0] OFF_CTRLA0 = 8'h00;
   localparam logic [APB_AW-1:0] OFF_CTRLB0 = 8'h04;
   localparam logic [APB_AW-1:0] OFF_CTRLA1 = 8'h08;
   localparam logic [APB_AW-1:0] OFF_CTRLB1 = 8'h0C;
   localparam logic [APB_AW-1:0] OFF_MIRROR = 8'h10;
   localparam logic [APB_AW-1:0] OFF_FLAGS = 8'h14;
   localparam logic [APB_AW-1:0] OFF_ANALOG_PIN_SELECT = 8'h18;
   localparam logic [APB_AW-1:0] OFF_PORT = 8'h1C;

   // cmp_control_a field positions
   localparam int CA_EN = 7;
   localparam int CA_OUT = 6;
   localparam int CA_POL = 4;
   localparam int CA_ZLF = 3;
   localparam int CA_SP = 2;
   localparam int CA_HYS = 1;
   localparam int CA_SYNC = 0;
   // cmp_control_b field positions
   localparam int CB_RISE = 7;
   localparam int CB_FALL = 6;
   localparam int CB_PCH_LSB = 3;
   localparam int CB_NCH_LSB = 0;
   localparam int CH_W = 3;

   // reset values
   localparam logic [BYTE_W-1:0] CTRLA_RST = 8'h04;
   localparam logic [BYTE_W-1:0] CTRLB_RST = 8'h00;
   localparam logic [PORT_W-1:0] ANALOG_PIN_SELECT_RST = 8'hFF;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // channel codes
   localparam logic [CH_W-1:0] PCH_PIN = 3'h0;
   localparam logic [CH_W-1:0] PCH_DAC = 3'h5;
   localparam logic [CH_W-1:0] PCH_FVR = 3'h6;
   localparam logic [CH_W-1:0] PCH_GND = 3'h7;
   localparam logic [CH_W-1:0] NCH_PIN_LAST = 3'h3;
   localparam logic [CH_W-1:0] NCH_FVR = 3'h6;
   localparam logic [CH_W-1:0] NCH_GND = 3'h7;
   localparam logic [CH_W-1:0] NCH_AMP_SHARED = 3'h1;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int FILT_HOLD_NS = 20;
   localparam int FILT_HOLD_CYC = (FILT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic en;
      logic pol;
      logic zlf;
      logic sp;
      logic hys;
      logic sync;
      logic rise;
      logic fall;
      logic [CH_W-1:0] pch;
      logic [CH_W-1:0] nch;
   } dcc_cfg_t;

   typedef struct packed {
      logic gnd;
      logic fixed_reference_buffer;
      logic dac;
      logic pin;
   } dcc_pos_t;

   typedef struct packed {
      logic gnd;
      logic fixed_reference_buffer;
      logic [3:0] pin;
   } dcc_neg_t;

   typedef struct packed {
      logic en;
      logic speed;
      logic hyst;
      dcc_pos_t pos;
      dcc_neg_t neg;
      logic ampRoute;
   } dcc_ana_t;
endpackage
`default_nettype wire

// file: logic/dcc_glitch_filter.sv
// zero latency anti-oscillation filter for one comparator output
`default_nettype none
module dcc_glitch_filter #(
   parameter int HOLD = dcc_pkg::FILT_HOLD_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // control and data
   input wire logic enable,
   input wire logic din,
   output logic dout
);
   localparam int CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD);
   localparam logic [CW-1:0] ZERO = '0;
   localparam logic [CW-1:0] ONE = CW'(1);

   logic state_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   wire logic holding = enable && (cnt_q != ZERO);

   // a change passes at once; only its reversal is held back
   assign dout = holding ? state_q : din;
   assign cnt_d = !enable ? ZERO :
                  (dout != state_q) ? HOLD_LOAD :
                  (cnt_q != ZERO) ? cnt_q - ONE : ZERO;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= 1'b0;
         cnt_q <= ZERO;
      end else begin
         state_q <= dout;
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// file: verification/dcc_ana_model.sv
// behavioural analog sources and comparator decisions for both channels
`default_nettype none
module dcc_ana_model
   import dcc_pkg::*;
(
   // routing from the block
   input wire dcc_pkg::dcc_ana_t [dcc_pkg::NUM_CMP-1:0] anaCtl,
   // levels: pos pin, converter, reference, amplifier, negative pins 0 to 3
   input wire logic [7:0][7:0] lvl,
   // decisions
   output logic [dcc_pkg::NUM_CMP-1:0] cmpRaw
);
   timeunit 1ns;
   timeprecision 1ns;
   // floating inputs read as zero: no kinder than ground, keeps the model small
   function automatic logic decide(input dcc_ana_t a, input logic [7:0][7:0] v);
      logic [7:0] p;
      logic [7:0] n;
      p = a.pos.pin ? v[0] : a.pos.dac ? v[1] : a.pos.fixed_reference_buffer ? v[2] : 8'h00;
      n = a.neg.fixed_reference_buffer ? v[2] : 8'h00;
      for (int k = 0; k < 4; k++) begin
         if (a.neg.pin[k]) n = v[4 + k];
      end
      if (a.ampRoute) n = v[3];
      return a.en && (p > n);
   endfunction
   always_comb begin
      for (int c = 0; c < NUM_CMP; c++) begin
         cmpRaw[c] = decide(anaCtl[c], lvl);
      end
   end
endmodule
`default_nettype wire

// file: verification/dcc_comparator_ctrl_chk.sv
// port assertions for the dual comparator control block
`default_nettype none
module dcc_comparator_ctrl_chk
   import dcc_pkg::*;
#(
   parameter int FILT_CYC = 2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dcc_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // analog, timer, pins and results
   input wire logic [dcc_pkg::NUM_CMP-1:0] cmpRaw,
   input wire logic [dcc_pkg::NUM_CMP-1:0] ampEnable,
   input wire dcc_pkg::dcc_ana_t [dcc_pkg::NUM_CMP-1:0] anaCtl,
   input wire logic timerClk,
   input wire logic [dcc_pkg::NUM_CMP-1:0] timerGate,
   input wire logic [dcc_pkg::NUM_CMP-1:0] pinOut,
   input wire logic [dcc_pkg::NUM_CMP-1:0] pinOutAllowed,
   input wire logic [dcc_pkg::PORT_W-1:0] portPins,
   input wire logic [dcc_pkg::NUM_CMP-1:0] cmpResult,
   input wire logic [dcc_pkg::NUM_CMP-1:0] cmpIrqFlag
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   logic acc;
   logic mapped;
   assign acc = psel && penable;
   assign mapped = paddr[1:0] == 2'h0 && paddr <= OFF_PORT;
   a_ready_access: assert property (pready == acc)
      else $error("pready differs from access");
   a_err_unmapped: assert property (acc |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   a_mirror_read: assert property (acc && !pwrite && paddr == OFF_MIRROR |->
      prdata == {30'h0, $past(cmpResult)}) else $error("mirror read differs");
   c_err: cover property (acc && pslverr);
   c_mirror: cover property (acc && !pwrite && paddr == OFF_MIRROR && prdata[0]);
   for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
      logic clr;
      assign clr = acc && pwrite && paddr == OFF_FLAGS && pwdata[i];
      a_off_isolated: assert property (!anaCtl[i].en |-> anaCtl[i].pos == '0 &&
         anaCtl[i].neg == '0 && !anaCtl[i].ampRoute) else $error("inputs not released");
      a_one_source: assert property ($countones(anaCtl[i].pos) <= 1 &&
         $countones(anaCtl[i].neg) <= 1) else $error("two sources selected");
      a_allow_enable: assert property (pinOutAllowed[i] == anaCtl[i].en)
         else $error("pin allow differs from enable");
      a_flag_sticky: assert property (cmpIrqFlag[i] && !clr |=> cmpIrqFlag[i])
         else $error("flag dropped without clear");
      a_flag_cause: assert property ($rose(cmpIrqFlag[i]) |->
         $past(cmpResult[i]) != $past(cmpResult[i], 2)) else $error("flag without edge");
      a_flag_clear: assert property (clr && cmpResult[i] == $past(cmpResult[i]) |=>
         !cmpIrqFlag[i]) else $error("flag not cleared");
      c_flag: cover property ($rose(cmpIrqFlag[i]));
   end
endmodule
bind dcc_comparator_ctrl dcc_comparator_ctrl_chk #(.FILT_CYC(FILT_CYC))
   dcc_comparator_ctrl_chk_inst (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .cmpRaw, .ampEnable, .anaCtl, .timerClk, .timerGate,
   .pinOut, .pinOutAllowed, .portPins, .cmpResult, .cmpIrqFlag);
`default_nettype wire

// file: verification/dcc_comparator_ctrl_tb_top.sv
// self-checking bench for the dual comparator control block
`default_nettype none
module dcc_comparator_ctrl_tb_top
   import dcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int FILT = 2;
   localparam int LIMIT = 6000;
   localparam logic [7:0] ROWB [10] = '{8'h00, 8'h28, 8'h30, 8'h38, 8'h10, 8'h01, 8'h02,
      8'h03, 8'h06, 8'h07};
   localparam logic [9:0] ROWE = 10'b1001100111;
   logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic timerClk = 1'b1, rdErr;
   logic [7:0] paddr = 8'h00, portPins = 8'hA5;
   logic [31:0] pwdata = 32'h0, prdata, rdData;
   logic [1:0] ampEnable = 2'b00, cmpRaw, timerGate, pinOut, pinOutAllowed, cmpResult;
   logic [1:0] cmpIrqFlag;
   logic pready, pslverr;
   logic [7:0][7:0] lvl = {8'h3C, 8'h19, 8'h0A, 8'h14, 8'h5A, 8'h28, 8'h32, 8'h1E};
   dcc_ana_t [1:0] anaCtl;
   int fails = 0, total_checks = 0, cycles = 0;
   dcc_comparator_ctrl #(.FILT_CYC(FILT)) dcc_comparator_ctrl_inst (.ref_clk, .sys_rst,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmpRaw,
      .ampEnable, .anaCtl, .timerClk, .timerGate, .pinOut, .pinOutAllowed, .portPins,
      .cmpResult, .cmpIrqFlag);
   dcc_ana_model dcc_ana_model_inst (.anaCtl, .lvl, .cmpRaw);
   always #5 ref_clk = ~ref_clk;
   task automatic end_of_test();
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; starts on a fresh edge so no signal is driven twice at once
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h00_0000, data};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // synchroniser plus result register take about five edges
   task automatic waitr(input int i, input logic e);
      repeat (6) @(posedge ref_clk);
      for (int k = 0; k < 20 && cmpResult[i] !== e; k++) @(posedge ref_clk);
      chk("cmpResult", {31'h0, e}, {31'h0, cmpResult[i]});
   endtask
   task automatic flagchk(input logic [1:0] e);
      repeat (3) @(posedge ref_clk);
      chk("cmpIrqFlag", {30'h0, e}, {30'h0, cmpIrqFlag});
   endtask
   task automatic t_reset();
      xfer(1'b0, OFF_CTRLA0, 8'h00);
      chk("ctrlA0", 32'h4, rdData);
      chk("speed", 32'h1, {31'h0, anaCtl[0].speed});
      xfer(1'b1, OFF_CTRLA1, 8'h00);
      xfer(1'b0, OFF_CTRLA1, 8'h00);
      chk("ctrlA1", 32'h0, rdData);
      chk("speed", 32'h0, {31'h0, anaCtl[1].speed});
      xfer(1'b0, 8'h24, 8'h00);
      chk("unmapped", 32'h1, {31'h0, rdErr});
      xfer(1'b1, OFF_ANALOG_PIN_SELECT, 8'h0F);
      xfer(1'b0, OFF_PORT, 8'h00);
      chk("portData", 32'hA0, rdData);
   endtask
   task automatic t_route();
      xfer(1'b1, OFF_CTRLA0, 8'h84);
      for (int k = 0; k < 10; k++) begin
         xfer(1'b1, OFF_CTRLB0, ROWB[k]);
         waitr(0, ROWE[k]);
      end
      xfer(1'b0, OFF_MIRROR, 8'h00);
      chk("mirror", 32'h1, rdData);
      chk("pinOutAllowed", 32'h1, {30'h0, pinOutAllowed});
      xfer(1'b0, OFF_CTRLA0, 8'h00);
      chk("ctrlA0", 32'hC4, rdData);
      ampEnable <= 2'b01;
      xfer(1'b1, OFF_CTRLB0, 8'h01);
      waitr(0, 1'b0);
      xfer(1'b1, OFF_CTRLA0, 8'h94);
      waitr(0, 1'b1);
   endtask
   task automatic t_irq();
      xfer(1'b1, OFF_CTRLB1, 8'h80);
      xfer(1'b1, OFF_CTRLA1, 8'h14);
      waitr(1, 1'b1);
      flagchk(2'b10);
      xfer(1'b0, OFF_FLAGS, 8'h00);
      chk("flags", 32'h2, rdData);
      xfer(1'b1, OFF_FLAGS, 8'h02);
      flagchk(2'b00);
      xfer(1'b1, OFF_CTRLA1, 8'h04);
      waitr(1, 1'b0);
      flagchk(2'b00);
      xfer(1'b1, OFF_CTRLA1, 8'h84);
      waitr(1, 1'b1);
      flagchk(2'b10);
      xfer(1'b1, OFF_FLAGS, 8'h02);
      xfer(1'b1, OFF_CTRLB1, 8'h40);
      xfer(1'b1, OFF_CTRLA1, 8'h94);
      waitr(1, 1'b0);
      flagchk(2'b10);
   endtask
   task automatic pulse(input logic [7:0] ctl, input int expW);
      int w = 0;
      xfer(1'b1, OFF_CTRLA0, ctl);
      @(posedge ref_clk);
      lvl[0] <= 8'h1E;
      // two cycles: the synchroniser drops anything shorter
      @(posedge ref_clk);
      @(posedge ref_clk);
      lvl[0] <= 8'h00;
      repeat (12) begin
         @(posedge ref_clk);
         w = w + int'(cmpResult[0] === 1'b1);
      end
      chk("pulseWidth", expW, w);
   endtask
   task automatic t_filter();
      ampEnable <= 2'b00;
      lvl[0] <= 8'h00;
      xfer(1'b1, OFF_CTRLB0, 8'h00);
      xfer(1'b1, OFF_CTRLA0, 8'h84);
      waitr(0, 1'b0);
      pulse(8'h84, 2);
      pulse(8'h8C, FILT + 1);
   endtask
   task automatic t_sync();
      xfer(1'b1, OFF_CTRLA0, 8'h87);
      lvl[0] <= 8'h1E;
      waitr(0, 1'b1);
      chk("hyst", 32'h1, {31'h0, anaCtl[0].hyst});
      chk("timerGate", 32'h0, {31'h0, timerGate[0]});
      timerClk <= 1'b0;
      for (int k = 0; k < 10 && timerGate[0] !== 1'b1; k++) @(posedge ref_clk);
      chk("timerGate", 32'h1, {31'h0, timerGate[0]});
      chk("pinOut", 32'h1, {31'h0, pinOut[0]});
      timerClk <= 1'b1;
      xfer(1'b1, OFF_CTRLA0, 8'h84);
      lvl[0] <= 8'h00;
      waitr(0, 1'b0);
      chk("timerGate", 32'h0, {31'h0, timerGate[0]});
      chk("pinOut", 32'h0, {31'h0, pinOut[0]});
      chk("hyst", 32'h0, {31'h0, anaCtl[0].hyst});
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_route();
      t_irq();
      t_filter();
      t_sync();
      end_of_test();
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails = fails + 1;
         end_of_test();
      end
   end
endmodule
`default_nettype wire
